// File: src/rf_bit_timer_regs.vh
// Register map, field positions and constants for the RF bit timer
// What this block does
// - Function 00 off, 01 transmit unkeyed, 10 receive, 11 transmit keyed.
// - Interrupt enable gates both flags onto their interrupt requests.
// - Buffer-empty/overflow vectors to address 0x04, done/edge to 0x02.
// - Transmit sets done flag when buffer empty and counter reaches zero.
// - Receive sets done/edge flag on any edge of the edge input pin.
// - Reading the control register clears both flags.
// - Taking the buffered bit sets buffer-empty flag for software reload.
// - Receive loads data bit with 1 for rising, 0 for falling edge.
// - Receive count holds system clock cycles since the previous edge.
// - Counter overflow in receive sets the overflow flag; software extends.
// - System clock is crystal over 16, 32 or 64 for codes 11, 10, 01.
// - Each mark or space lasts count value plus one system clocks.
// - Count is ten bits: top two in control bits 7:6, low eight in count.
// - Divide select 00 gives crystal/128; select may change on the fly.
`ifndef RF_BIT_TIMER_REGS_VH
`define RF_BIT_TIMER_REGS_VH
`define ADDR_BIT_TIMER_COUNT    6'h20
`define ADDR_BIT_TIMER_CONTROL  6'h21
`define ADDR_PROCESSOR_CONFIG   6'h33
`define CTL_BUF_EMPTY_BIT       0
`define CTL_DATA_BIT            1
`define CTL_DONE_EDGE_BIT       2
`define CTL_INT_EN_BIT          3
`define CTL_MODE_LO             4
`define CTL_MODE_HI             5
`define CTL_CNT_LO              6
`define CTL_CNT_HI              7
`define CFG_CLK_SEL_LO          5
`define CFG_CLK_SEL_HI          6
`define RST_BYTE                8'h00
`define MODE_OFF                2'h0
`define MODE_TX_UNKEYED         2'h1
`define MODE_RX                 2'h2
`define MODE_TX_KEYED           2'h3
`define VEC_BUF_EMPTY_OVF       8'h04
`define VEC_DONE_EDGE           8'h02
`endif

// File: src/rf_bit_timer.v
// Bit timer with crystal clock divider, transmit serialiser and edge timer
`timescale 1ns/100ps
`include "rf_bit_timer_regs.vh"
module rf_bit_timer (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire [5:0] io_addr,
  input  wire       io_wr,
  input  wire       io_rd,
  input  wire [7:0] io_wdata,
  output reg  [7:0] io_rdata,
  input  wire       edge_input_pin,
  output reg        tx_key,
  output reg        tx_enable,
  output wire       sys_clk_en,
  output wire       irq_buf_empty_ovf,
  output wire       irq_done_edge,
  output wire [7:0] irq_vec_buf_empty_ovf,
  output wire [7:0] irq_vec_done_edge
);
  reg  [7:0] count_lo_r;
  reg  [1:0] count_hi_r;
  reg  [1:0] mode_r;
  reg        int_en_r;
  reg        data_r;
  reg        buf_empty_ovf_r;
  reg        done_edge_r;
  reg  [1:0] clk_sel_r;
  reg  [6:0] div_r;
  reg  [9:0] cnt_r;
  reg        buf_full_r;
  reg        running_r;
  reg        pin_s1_r;
  reg        pin_s2_r;
  reg        pin_last_r;
  reg  [6:0] div_mask;
  wire [9:0] countval = {count_hi_r, count_lo_r};
  wire       tx_mode  = mode_r[0];
  wire       rx_mode  = (mode_r == `MODE_RX);
  wire       wr_cnt   = io_wr && (io_addr == `ADDR_BIT_TIMER_COUNT);
  wire       wr_ctl   = io_wr && (io_addr == `ADDR_BIT_TIMER_CONTROL);
  wire       wr_cfg   = io_wr && (io_addr == `ADDR_PROCESSOR_CONFIG);
  wire       rd_ctl   = io_rd && (io_addr == `ADDR_BIT_TIMER_CONTROL);
  wire       tick;
  wire       edge_det;
  wire       bit_end;
  wire       take_bit;
  wire       tx_done;
  wire       rx_ovf;
  // Cycles since the previous edge, including the tick that saw this one
  wire [9:0] rx_elapsed = cnt_r + 10'h001;

  // Divider mask per select code; change takes effect on the fly
  always @* begin
    case (clk_sel_r)
      2'h3:    div_mask = 7'h0F;
      2'h2:    div_mask = 7'h1F;
      2'h1:    div_mask = 7'h3F;
      default: div_mask = 7'h7F;
    endcase
  end

  assign tick       = ((div_r & div_mask) == div_mask);
  assign sys_clk_en = tick;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 7'h00;
    end else begin
      div_r <= div_r + 7'h01;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= edge_input_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign edge_det = tick && rx_mode && (pin_s2_r != pin_last_r);
  assign bit_end  = tick && tx_mode && (!running_r || cnt_r == 10'h000);
  assign take_bit = bit_end && buf_full_r;
  assign tx_done  = bit_end && !buf_full_r && running_r;
  assign rx_ovf   = tick && rx_mode && !edge_det && (cnt_r == 10'h3FF);

  // Timer core: transmit serialiser and receive edge timer
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r      <= 10'h000;
      running_r  <= 1'b0;
      buf_full_r <= 1'b0;
      tx_key     <= 1'b0;
      pin_last_r <= 1'b0;
      data_r     <= 1'b0;
    end else begin
      if (tick) begin
        pin_last_r <= pin_s2_r;
      end
      if (wr_ctl) begin
        data_r     <= io_wdata[`CTL_DATA_BIT];
        buf_full_r <= io_wdata[`CTL_MODE_LO];
      end
      if (!tx_mode) begin
        running_r <= 1'b0;
        tx_key    <= 1'b0;
      end
      if (take_bit) begin
        cnt_r      <= countval;
        tx_key     <= data_r;
        running_r  <= 1'b1;
        buf_full_r <= 1'b0;
      end else if (tx_done) begin
        running_r <= 1'b0;
        tx_key    <= 1'b0;
      end else if (tick && tx_mode && running_r) begin
        cnt_r <= cnt_r - 10'h001;
      end else if (edge_det) begin
        data_r <= pin_s2_r;
        cnt_r  <= 10'h000;
      end else if (tick && rx_mode) begin
        cnt_r <= cnt_r + 10'h001;
      end else if (mode_r == `MODE_OFF) begin
        cnt_r <= 10'h000;
      end
    end
  end

  // Software registers; hardware flag set wins over read clear
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_lo_r <= `RST_BYTE;
      count_hi_r      <= 2'h0;
      mode_r          <= `MODE_OFF;
      int_en_r        <= 1'b0;
      clk_sel_r       <= 2'h0;
      buf_empty_ovf_r <= 1'b0;
      done_edge_r     <= 1'b0;
      tx_enable       <= 1'b0;
    end else begin
      // In receive the count registers hold the interval of the last edge
      if (wr_cnt) begin
        count_lo_r <= io_wdata;
      end else if (edge_det) begin
        count_lo_r <= rx_elapsed[7:0];
      end
      if (wr_ctl) begin
        count_hi_r <= io_wdata[`CTL_CNT_HI:`CTL_CNT_LO];
        mode_r     <= io_wdata[`CTL_MODE_HI:`CTL_MODE_LO];
        int_en_r   <= io_wdata[`CTL_INT_EN_BIT];
      end else if (edge_det) begin
        count_hi_r <= rx_elapsed[9:8];
      end
      if (wr_cfg) begin
        clk_sel_r <= io_wdata[`CFG_CLK_SEL_HI:`CFG_CLK_SEL_LO];
      end
      tx_enable <= (mode_r == `MODE_TX_KEYED);
      if (take_bit || rx_ovf) begin
        buf_empty_ovf_r <= 1'b1;
      end else if (rd_ctl) begin
        buf_empty_ovf_r <= 1'b0;
      end
      if (tx_done || edge_det) begin
        done_edge_r <= 1'b1;
      end else if (rd_ctl) begin
        done_edge_r <= 1'b0;
      end
    end
  end

  always @* begin
    case (io_addr)
      `ADDR_BIT_TIMER_COUNT:   io_rdata = count_lo_r;
      `ADDR_BIT_TIMER_CONTROL: io_rdata = {count_hi_r, mode_r, int_en_r,
                                           done_edge_r, data_r,
                                           buf_empty_ovf_r};
      `ADDR_PROCESSOR_CONFIG:  io_rdata = {1'b0, clk_sel_r, 5'h00};
      default:                 io_rdata = 8'h00;
    endcase
  end

  assign irq_buf_empty_ovf     = int_en_r && buf_empty_ovf_r;
  assign irq_done_edge         = int_en_r && done_edge_r;
  assign irq_vec_buf_empty_ovf = `VEC_BUF_EMPTY_OVF;
  assign irq_vec_done_edge     = `VEC_DONE_EDGE;
endmodule

// File: tb/rf_bit_timer_sva.sv
// Port checker for the RF bit timer
`timescale 1ns/100ps
module rf_bit_timer_sva (
  input wire logic       ref_clk, sys_rst, io_wr, io_rd, tx_key,
  input wire logic       tx_enable, sys_clk_en,
  input wire logic       irq_buf_empty_ovf, irq_done_edge,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_rdata, irq_vec_buf_empty_ovf, irq_vec_done_edge
);
  wire rd_c = io_rd && io_addr == 6'h21;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_vec_fixed: assert property (irq_vec_done_edge == 8'h02 &&
    irq_vec_buf_empty_ovf == 8'h04) else $error("bad vector");
  chk_irq_gate: assert property (rd_c |-> irq_done_edge ==
    &io_rdata[3:2] && irq_buf_empty_ovf == (io_rdata[3] & io_rdata[0]))
    else $error("bad irq");
  chk_rd_clear: assert property (rd_c && !sys_clk_en |=>
    !irq_done_edge && !irq_buf_empty_ovf) else $error("flag kept");
  chk_tick_gap: assert property (sys_clk_en |=>
    !sys_clk_en [*8] ##1 !sys_clk_en [*7]) else $error("tick early");
  chk_tx_enable: assert property (rd_c && !$past(io_wr) |->
    tx_enable == &io_rdata[5:4]) else $error("bad enable");
  chk_key_idle: assert property (rd_c && !$past(io_wr) &&
    !io_rdata[4] |-> !tx_key) else $error("key idle");
  chk_key_tick: assert property ($changed(tx_key) |->
    $past(sys_clk_en) || $past(io_wr, 2)) else $error("key off tick");
  chk_unmapped_zero: assert property (io_addr != 6'h20 &&
    io_addr != 6'h21 && io_addr != 6'h33 |-> io_rdata == 8'h00)
    else $error("unmapped data");
  cover property (rd_c && io_rdata[2]);
  cover property ($rose(irq_buf_empty_ovf));
  cover property ($rose(tx_key));
endmodule
bind rf_bit_timer rf_bit_timer_sva u_chk (.*);

// File: tb/rf_far_side.sv
// Keying receiver and edge source on the far side of the bit timer
`timescale 1ns/100ps
module rf_far_side (
  input  wire logic ref_clk,
  input  wire logic tx_key,
  input  wire logic level,
  output wire logic edge_input_pin,
  output int        key_len
);
  int run;
  // Length of the last mark in crystal cycles
  always @(posedge ref_clk) begin
    run <= tx_key ? run + 1 : 0;
    if (!tx_key && run != 0)
      key_len <= run;
  end
  assign #1 edge_input_pin = level;
endmodule

// File: tb/rf_bit_timer_tb.sv
// Self-checking bench for the RF bit timer
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  mismatches++; $display("wrong value %0t %h %h", $time, a, b); end end
module rf_bit_timer_tb;
  logic       ref_clk = 0, sys_rst = 1, io_wr = 0, io_rd = 0, level = 0;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00, d;
  logic [5:0] al [4] = '{6'h20, 6'h21, 6'h33, 6'h3F};
  wire  [7:0] io_rdata, irq_vec_buf_empty_ovf, irq_vec_done_edge;
  wire        tx_key, tx_enable, sys_clk_en, edge_input_pin;
  wire        irq_buf_empty_ovf, irq_done_edge;
  int         mismatches, samples_checked, cyc, key_len, n, m;
  bit  [31:0] seed = 99;
  always #2 ref_clk = ~ref_clk;
  rf_bit_timer u_dut (.*);
  rf_far_side u_far (.*);
  function automatic int rnd(int lim);
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed % lim;
  endfunction
  task automatic wr(input [5:0] a, input [7:0] v);
    @(negedge ref_clk) {io_addr, io_wdata, io_wr} = {a, v, 1'b1};
    @(negedge ref_clk) io_wr = 0;
  endtask
  task automatic rd(input [5:0] a);
    @(negedge ref_clk) {io_addr, io_rd} = {a, 1'b1};
    @(posedge ref_clk) d = io_rdata;
    @(negedge ref_clk) io_rd = 0;
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge ref_clk iff sys_clk_en);
    #1;
  endtask
  task report_and_stop;
    $display("mismatches %0d checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    sys_rst = 0;
    for (n = 0; n < 4; n++) begin
      rd(al[n]);
      `CHK(d, 8'h00)
    end
    for (n = 0; n < 4; n++) begin
      m = rnd(256);
      wr(6'h33, {m[7], n[1:0], m[4:0]});
      rd(6'h33);
      `CHK(d, {1'b0, n[1:0], 5'h00})
      ticks(1);
      m = cyc;
      ticks(1);
      `CHK(cyc - m, 128 >> n)
    end
    // Receive with interrupts on; edges land just after a tick
    wr(6'h21, 8'h28);
    rd(6'h21);
    ticks(1);
    level = 1;
    ticks(2);
    for (n = 0; n < 4; n++) begin
      m = 4 + rnd(28);
      ticks(m - 2);
      level = ~level;
      ticks(2);
      `CHK(irq_done_edge, 1'b1)
      rd(6'h21);
      `CHK(d, {6'h0B, level, 1'b0})
      rd(6'h20);
      `CHK(d == m || d + 1 == m, 1'b1)
    end
    // Transmit one mark in each transmit mode, no reload
    for (n = 1; n < 4; n += 2) begin
      m = 2 + rnd(12);
      wr(6'h20, m[7:0]);
      wr(6'h21, {2'b00, n[1:0], n[1], 3'b010});
      ticks(m + 4);
      `CHK(key_len, (m + 1) * 16)
      `CHK(tx_enable, n[1])
      `CHK(irq_done_edge, n[1])
      rd(6'h21);
      `CHK(d & 8'h05, 8'h05)
      rd(6'h21);
      `CHK(d & 8'h05, 8'h00)
    end
    report_and_stop;
  end
endmodule
